// file: hw/dcw3_config_word.sv
`timescale 1ns/100ps
module dcw3_config_word
#(
   parameter bit HAS_ALT_ETH_PINS = 1'b1
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // nonvolatile storage read port
   output logic             nv_rd_en,
   output logic [2:0]       nv_addr,
   input  wire logic [31:0] nv_rd_data,
   // usb identification pin routing
   input  wire logic        usb_ident_pin,
   output logic             usb_id_to_usb,
   output logic             usb_id_to_port,
   output logic             usb_id_owner_usb,
   // ethernet pin and interface choice
   output logic             eth_default_pins,
   output logic             eth_full_mii,
   // reconfigurable settings guarded by one-way locks
   output logic [31:0]      pin_map_cfg,
   output logic [31:0]      mod_dis_cfg,
   output logic [31:0]      perm_grp_cfg,
   // user identifier towards the debug ports
   output logic [15:0]      serial_prog_user_id,
   output logic [15:0]      jtag_user_id,
   // load status
   output logic             cfg_loaded
);

   // loader state
   dcw3_pkg::dcw3_state_t state_reg;
   dcw3_pkg::dcw3_state_t state_next;
   logic [2:0]            slot_reg;
   logic [2:0]            slot_next;
   logic                  nv_rd_en_reg;
   logic                  loaded_reg;

   // captured words
   logic [31:0]           nv_word_reg [0:dcw3_pkg::NV_SLOTS-1];
   wire  [31:0]           pri_cfg3;

   // software control
   logic                  usb_module_off_setting_reg;

   // decoded output registers
   logic                  usb_owner_reg;
   logic                  usb_to_usb_reg;
   logic                  usb_to_port_reg;
   logic                  eth_default_reg;
   logic                  eth_full_reg;
   logic [15:0]           serial_id_reg;
   logic [15:0]           jtag_id_reg;
   logic [31:0]           pin_map_out_reg;
   logic [31:0]           mod_dis_out_reg;
   logic [31:0]           perm_grp_out_reg;
   logic [31:0]           rdata_reg;

   // lock module outputs
   wire  [31:0]           pin_map_val;
   wire  [31:0]           mod_dis_val;
   wire  [31:0]           perm_grp_val;
   wire                   pin_map_used;
   wire                   mod_dis_used;
   wire                   perm_grp_used;

   // synchronised pad
   wire                   usb_ident_sync;

   // configuration fields
   wire                   usb_id_owner_usb_bit;
   wire                   pin_select_one_way_lock;
   wire                   module_disable_one_way_lock;
   wire                   permission_group_one_way_lock;
   wire                   ethernet_pin_set_select;
   wire                   ethernet_full_interface_select;
   wire  [15:0]           user_identifier;
   wire                   usb_owner_eff;

   // register decode
   wire                   hit_control;
   wire                   hit_pin_map;
   wire                   hit_mod_dis;
   wire                   hit_perm_grp;
   wire                   hit_pri_cfg3;
   wire                   hit_status;
   wire                   hit_alt3;
   wire                   hit_alt2;
   wire                   hit_alt1;
   wire                   hit_alt0;
   wire                   wr_pin_map;
   wire                   wr_mod_dis;
   wire                   wr_perm_grp;
   wire  [31:0]           status_word;
   wire  [31:0]           control_word;
   wire  [31:0]           alt3_readback;
   wire  [31:0]           rd_mux;

   // pad synchroniser
   dcw3_sync2 u_id_sync
   (
      .clk     (clk),
      .reset_n (reset_n),
      .din     (usb_ident_pin),
      .dout    (usb_ident_sync)
   );

   // loader: reads five words from storage once after reset
   always_comb
   begin
      state_next = state_reg;
      slot_next  = slot_reg;
      case (state_reg)
         dcw3_pkg::DCW3_ST_ISSUE:
         begin
            if (nv_rd_en_reg)
            begin
               state_next = dcw3_pkg::DCW3_ST_WAIT;
            end
         end
         dcw3_pkg::DCW3_ST_WAIT:
         begin
            if (slot_reg == dcw3_pkg::NV_SLOT_LAST)
            begin
               state_next = dcw3_pkg::DCW3_ST_DONE;
            end
            else
            begin
               state_next = dcw3_pkg::DCW3_ST_ISSUE;
               slot_next  = slot_reg + 3'h1;
            end
         end
         dcw3_pkg::DCW3_ST_DONE:
         begin
            state_next = dcw3_pkg::DCW3_ST_DONE;
         end
         default:
         begin
            state_next = dcw3_pkg::DCW3_ST_ISSUE;
            slot_next  = dcw3_pkg::NV_SLOT_PRI;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_reg    <= dcw3_pkg::DCW3_ST_ISSUE;
         slot_reg     <= dcw3_pkg::NV_SLOT_PRI;
         nv_rd_en_reg <= 1'b0;
         loaded_reg   <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         slot_reg     <= slot_next;
         nv_rd_en_reg <= (state_next == dcw3_pkg::DCW3_ST_ISSUE) && !nv_rd_en_reg;
         loaded_reg   <= (state_next == dcw3_pkg::DCW3_ST_DONE);
      end
   end

   // storage answers one cycle after the read, in the wait state
   genvar gi;
   generate
      for (gi = 0; gi < dcw3_pkg::NV_SLOTS; gi = gi + 1)
      begin : g_word
         always_ff @(posedge clk)
         begin
            if (!reset_n)
            begin
               nv_word_reg[gi] <= '0;
            end
            else if ((state_reg == dcw3_pkg::DCW3_ST_WAIT) && (slot_reg == 3'(gi)))
            begin
               nv_word_reg[gi] <= nv_rd_data;
            end
         end
      end
   endgenerate

   // field decode of the primary word
   assign pri_cfg3                       = nv_word_reg[dcw3_pkg::NV_SLOT_PRI];
   assign usb_id_owner_usb_bit           = pri_cfg3[dcw3_pkg::BIT_USB_ID_OWNER];
   assign pin_select_one_way_lock        = pri_cfg3[dcw3_pkg::BIT_PIN_SEL_LOCK];
   assign module_disable_one_way_lock    = pri_cfg3[dcw3_pkg::BIT_MOD_DIS_LOCK];
   assign permission_group_one_way_lock  = pri_cfg3[dcw3_pkg::BIT_PERM_GRP_LOCK];
   assign ethernet_pin_set_select        = pri_cfg3[dcw3_pkg::BIT_ETH_PIN_SET];
   assign ethernet_full_interface_select = pri_cfg3[dcw3_pkg::BIT_ETH_FULL_IF];
   assign user_identifier                = pri_cfg3[dcw3_pkg::USER_ID_MSB:0];

   // module-off setting overrides the ownership bit
   assign usb_owner_eff = loaded_reg && usb_id_owner_usb_bit && !usb_module_off_setting_reg;

   // one-way locked settings, writable only after the word is loaded
   assign wr_pin_map  = reg_wr && hit_pin_map && loaded_reg;
   assign wr_mod_dis  = reg_wr && hit_mod_dis && loaded_reg;
   assign wr_perm_grp = reg_wr && hit_perm_grp && loaded_reg;

   dcw3_one_way_reg #(.W(dcw3_pkg::DATA_W)) u_pin_map
   (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_pin_map),
      .wr_data (reg_wdata),
      .one_way (pin_select_one_way_lock),
      .value   (pin_map_val),
      .used    (pin_map_used)
   );

   dcw3_one_way_reg #(.W(dcw3_pkg::DATA_W)) u_mod_dis
   (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_mod_dis),
      .wr_data (reg_wdata),
      .one_way (module_disable_one_way_lock),
      .value   (mod_dis_val),
      .used    (mod_dis_used)
   );

   dcw3_one_way_reg #(.W(dcw3_pkg::DATA_W)) u_perm_grp
   (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_perm_grp),
      .wr_data (reg_wdata),
      .one_way (permission_group_one_way_lock),
      .value   (perm_grp_val),
      .used    (perm_grp_used)
   );

   // control register
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         usb_module_off_setting_reg <= 1'b0;
      end
      else if (reg_wr && hit_control)
      begin
         usb_module_off_setting_reg <= reg_wdata[dcw3_pkg::BIT_CTRL_USB_OFF];
      end
   end

   // decoded outputs, all registered; until loaded the identification pin routes to the port and the default ethernet pins are selected
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         usb_owner_reg    <= 1'b0;
         usb_to_usb_reg   <= 1'b0;
         usb_to_port_reg  <= 1'b0;
         eth_default_reg  <= 1'b1;
         eth_full_reg     <= 1'b0;
         serial_id_reg    <= '0;
         jtag_id_reg      <= '0;
         pin_map_out_reg  <= '0;
         mod_dis_out_reg  <= '0;
         perm_grp_out_reg <= '0;
      end
      else
      begin
         usb_owner_reg    <= usb_owner_eff;
         usb_to_usb_reg   <= usb_owner_eff && usb_ident_sync;
         usb_to_port_reg  <= !usb_owner_eff && usb_ident_sync;
         eth_default_reg  <= !HAS_ALT_ETH_PINS || !loaded_reg || ethernet_pin_set_select;
         eth_full_reg     <= loaded_reg && ethernet_full_interface_select;
         serial_id_reg    <= loaded_reg ? user_identifier : '0;
         jtag_id_reg      <= loaded_reg ? user_identifier : '0;
         pin_map_out_reg  <= pin_map_val;
         mod_dis_out_reg  <= mod_dis_val;
         perm_grp_out_reg <= perm_grp_val;
      end
   end

   // register read path
   assign hit_control  = (reg_addr == dcw3_pkg::ADDR_CONTROL);
   assign hit_pin_map  = (reg_addr == dcw3_pkg::ADDR_PIN_MAP);
   assign hit_mod_dis  = (reg_addr == dcw3_pkg::ADDR_MOD_DIS);
   assign hit_perm_grp = (reg_addr == dcw3_pkg::ADDR_PERM_GRP);
   assign hit_pri_cfg3 = (reg_addr == dcw3_pkg::ADDR_PRI_CFG3);
   assign hit_status   = (reg_addr == dcw3_pkg::ADDR_STATUS);
   assign hit_alt3     = (reg_addr == dcw3_pkg::ADDR_ALT_CFG3);
   assign hit_alt2     = (reg_addr == dcw3_pkg::ADDR_ALT_CFG2);
   assign hit_alt1     = (reg_addr == dcw3_pkg::ADDR_ALT_CFG1);
   assign hit_alt0     = (reg_addr == dcw3_pkg::ADDR_ALT_CFG0);

   assign control_word = {31'h0, usb_module_off_setting_reg};

   assign status_word  = {27'h0,
                          usb_owner_eff,
                          perm_grp_used,
                          mod_dis_used,
                          pin_map_used,
                          loaded_reg};

   // reserved positions of alternate word three read as one
   assign alt3_readback = nv_word_reg[dcw3_pkg::NV_SLOT_ALT3] | dcw3_pkg::CFG3_RSVD_MASK;

   assign rd_mux = hit_control  ? control_word :
                   hit_pin_map  ? pin_map_val :
                   hit_mod_dis  ? mod_dis_val :
                   hit_perm_grp ? perm_grp_val :
                   hit_pri_cfg3 ? pri_cfg3 :
                   hit_status   ? status_word :
                   hit_alt3     ? alt3_readback :
                   hit_alt2     ? nv_word_reg[dcw3_pkg::NV_SLOT_ALT2] :
                   hit_alt1     ? nv_word_reg[dcw3_pkg::NV_SLOT_ALT1] :
                   hit_alt0     ? nv_word_reg[dcw3_pkg::NV_SLOT_ALT0] :
                   32'h0;

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= reg_rd ? rd_mux : 32'h0;
      end
   end

   // output wiring
   assign reg_rdata           = rdata_reg;
   assign nv_rd_en            = nv_rd_en_reg;
   assign nv_addr             = slot_reg;
   assign usb_id_to_usb       = usb_to_usb_reg;
   assign usb_id_to_port      = usb_to_port_reg;
   assign usb_id_owner_usb    = usb_owner_reg;
   assign eth_default_pins    = eth_default_reg;
   assign eth_full_mii        = eth_full_reg;
   assign pin_map_cfg         = pin_map_out_reg;
   assign mod_dis_cfg         = mod_dis_out_reg;
   assign perm_grp_cfg        = perm_grp_out_reg;
   assign serial_prog_user_id = serial_id_reg;
   assign jtag_user_id        = jtag_id_reg;
   assign cfg_loaded          = loaded_reg;

endmodule : dcw3_config_word

// file: common/dcw3_pkg.sv
package dcw3_pkg;

   // register bus geometry
   localparam int              ADDR_W          = 16;
   localparam int              DATA_W          = 32;

   // register byte addresses
   localparam logic [15:0]     ADDR_CONTROL    = 16'hff20;
   localparam logic [15:0]     ADDR_PIN_MAP    = 16'hff24;
   localparam logic [15:0]     ADDR_MOD_DIS    = 16'hff28;
   localparam logic [15:0]     ADDR_PERM_GRP   = 16'hff2c;
   localparam logic [15:0]     ADDR_PRI_CFG3   = 16'hff30;
   localparam logic [15:0]     ADDR_STATUS     = 16'hff34;
   localparam logic [15:0]     ADDR_ALT_CFG3   = 16'hff40;
   localparam logic [15:0]     ADDR_ALT_CFG2   = 16'hff44;
   localparam logic [15:0]     ADDR_ALT_CFG1   = 16'hff48;
   localparam logic [15:0]     ADDR_ALT_CFG0   = 16'hff4c;

   // configuration word three field positions
   localparam int              BIT_USB_ID_OWNER  = 30;
   localparam int              BIT_PIN_SEL_LOCK  = 29;
   localparam int              BIT_MOD_DIS_LOCK  = 28;
   localparam int              BIT_PERM_GRP_LOCK = 27;
   localparam int              BIT_ETH_PIN_SET   = 25;
   localparam int              BIT_ETH_FULL_IF   = 24;
   localparam int              USER_ID_MSB       = 15;
   localparam int              USER_ID_W         = 16;

   // reserved positions of word three, forced to one when alternate word three is read
   localparam logic [31:0]     CFG3_RSVD_MASK  = 32'h84ff0000;

   // control and status field positions
   localparam int              BIT_CTRL_USB_OFF  = 0;
   localparam int              BIT_STAT_LOADED   = 0;
   localparam int              BIT_STAT_PIN_USED = 1;
   localparam int              BIT_STAT_MOD_USED = 2;
   localparam int              BIT_STAT_PG_USED  = 3;
   localparam int              BIT_STAT_USB_OWN  = 4;

   // nonvolatile word slots: primary word three, then alternates 3..0
   localparam logic [2:0]      NV_SLOT_PRI     = 3'h0;
   localparam logic [2:0]      NV_SLOT_ALT3    = 3'h1;
   localparam logic [2:0]      NV_SLOT_ALT2    = 3'h2;
   localparam logic [2:0]      NV_SLOT_ALT1    = 3'h3;
   localparam logic [2:0]      NV_SLOT_ALT0    = 3'h4;
   localparam logic [2:0]      NV_SLOT_LAST    = 3'h4;
   localparam int              NV_SLOTS        = 5;

   typedef enum logic [2:0]
   {
      DCW3_ST_ISSUE = 3'h1,
      DCW3_ST_WAIT  = 3'h2,
      DCW3_ST_DONE  = 3'h4
   } dcw3_state_t;

endpackage : dcw3_pkg

// file: hw/dcw3_sync2.sv
`timescale 1ns/100ps
module dcw3_sync2
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // asynchronous level in, synchronised level out
   input  wire logic din,
   output logic      dout
);

   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end

   assign dout = sync_reg;

endmodule : dcw3_sync2

// file: hw/dcw3_one_way_reg.sv
`timescale 1ns/100ps
module dcw3_one_way_reg
#(
   parameter int W = 32
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // write side
   input  wire logic         wr_en,
   input  wire logic [W-1:0] wr_data,
   input  wire logic         one_way,
   // held setting
   output logic [W-1:0]      value,
   output logic              used
);

   logic [W-1:0] value_reg;
   logic         used_reg;
   wire          accept;

   // once written, a one-way setting ignores further writes until reset
   assign accept = wr_en && !(one_way && used_reg);

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         value_reg <= '0;
         used_reg  <= 1'b0;
      end
      else if (accept)
      begin
         value_reg <= wr_data;
         used_reg  <= 1'b1;
      end
   end

   assign value = value_reg;
   assign used  = used_reg;

endmodule : dcw3_one_way_reg

// file: dv/dcw3_config_word_properties.sv
`timescale 1ns/100ps
module dcw3_config_word_chk
#(
   parameter bit HAS_ALT_ETH_PINS = 1'b1
)
(
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // nonvolatile storage read port
   input wire logic        nv_rd_en,
   input wire logic [2:0]  nv_addr,
   input wire logic [31:0] nv_rd_data,
   // usb identification pin routing
   input wire logic        usb_ident_pin,
   input wire logic        usb_id_to_usb,
   input wire logic        usb_id_to_port,
   input wire logic        usb_id_owner_usb,
   // ethernet choice
   input wire logic        eth_default_pins,
   input wire logic        eth_full_mii,
   // locked settings
   input wire logic [31:0] pin_map_cfg,
   input wire logic [31:0] mod_dis_cfg,
   input wire logic [31:0] perm_grp_cfg,
   // user identifier
   input wire logic [15:0] serial_prog_user_id,
   input wire logic [15:0] jtag_user_id,
   input wire logic        cfg_loaded
);
   logic pin_wr;

   default clocking dcw3_cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   assign pin_wr = reg_wr && (reg_addr == dcw3_pkg::ADDR_PIN_MAP);

   a_alt3_reserved_ones: assert property (reg_rd && reg_addr == dcw3_pkg::ADDR_ALT_CFG3 |=>
      (reg_rdata & dcw3_pkg::CFG3_RSVD_MASK) == dcw3_pkg::CFG3_RSVD_MASK)
      else $error("alternate word three reserved bits not one");
   a_nv_single_pulse: assert property (nv_rd_en |=> !nv_rd_en)
      else $error("storage read request longer than one cycle");
   a_nv_slot_order: assert property (nv_rd_en && nv_addr != dcw3_pkg::NV_SLOT_LAST |->
      ##2 (nv_rd_en && nv_addr == $past(nv_addr, 2) + 3'h1))
      else $error("storage slots not read in order");
   a_load_latency: assert property ($rose(reset_n) |-> !cfg_loaded [*8] ##[1:6] cfg_loaded)
      else $error("configuration load time out of range");
   a_settings_frozen: assert property (cfg_loaded && $past(cfg_loaded) |=>
      $stable(serial_prog_user_id) && $stable(eth_full_mii) && $stable(eth_default_pins))
      else $error("decoded settings changed after load");
   a_ids_match: assert property (serial_prog_user_id == jtag_user_id)
      else $error("user identifier copies differ");
   a_ids_unloaded: assert property (!cfg_loaded |-> serial_prog_user_id == 16'h0)
      else $error("user identifier shown before load");
   a_id_exclusive: assert property (!(usb_id_to_usb && usb_id_to_port))
      else $error("identification pin routed to both owners");
   a_pin_map_cause: assert property (!$stable(pin_map_cfg) |-> $past(pin_wr) || $past(pin_wr, 2))
      else $error("pin map changed without a write");
   a_no_alt_pins: assert property (!HAS_ALT_ETH_PINS |-> eth_default_pins)
      else $error("pin-set bit used on part without alternate pins");

   c_loaded: cover property ($rose(cfg_loaded));
   c_pin_write: cover property (pin_wr ##2 !$stable(pin_map_cfg));
   c_id_usb: cover property (usb_id_to_usb);
   c_id_port: cover property (usb_id_to_port);
endmodule : dcw3_config_word_chk

bind dcw3_config_word dcw3_config_word_chk #(.HAS_ALT_ETH_PINS(HAS_ALT_ETH_PINS)) chk_u
(
   .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_rd_en(nv_rd_en), .nv_addr(nv_addr), .nv_rd_data(nv_rd_data),
   .usb_ident_pin(usb_ident_pin), .usb_id_to_usb(usb_id_to_usb), .usb_id_to_port(usb_id_to_port),
   .usb_id_owner_usb(usb_id_owner_usb), .eth_default_pins(eth_default_pins), .eth_full_mii(eth_full_mii),
   .pin_map_cfg(pin_map_cfg), .mod_dis_cfg(mod_dis_cfg), .perm_grp_cfg(perm_grp_cfg),
   .serial_prog_user_id(serial_prog_user_id), .jtag_user_id(jtag_user_id), .cfg_loaded(cfg_loaded)
);

// file: dv/dcw3_config_word_tb_top.sv
`timescale 1ns/100ps
module dcw3_config_word_tb_top;
   logic        clk, reset_n, reg_wr, reg_rd, nv_rd_en, usb_ident_pin, cfg_loaded;
   logic        usb_id_to_usb, usb_id_to_port, usb_id_owner_usb, eth_default_pins, eth_full_mii, alt_eth_default;
   logic [15:0] reg_addr, serial_prog_user_id, jtag_user_id;
   logic [31:0] reg_wdata, reg_rdata, nv_rd_data, pin_map_cfg, mod_dis_cfg, perm_grp_cfg;
   logic [2:0]  nv_addr;
   logic [31:0] nv_mem [0:4];
   int          errors, compares, cycles;

   dcw3_config_word #(.HAS_ALT_ETH_PINS(1'b1)) dut_u
   (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_rd_en(nv_rd_en), .nv_addr(nv_addr), .nv_rd_data(nv_rd_data),
      .usb_ident_pin(usb_ident_pin), .usb_id_to_usb(usb_id_to_usb), .usb_id_to_port(usb_id_to_port),
      .usb_id_owner_usb(usb_id_owner_usb), .eth_default_pins(eth_default_pins), .eth_full_mii(eth_full_mii),
      .pin_map_cfg(pin_map_cfg), .mod_dis_cfg(mod_dis_cfg), .perm_grp_cfg(perm_grp_cfg),
      .serial_prog_user_id(serial_prog_user_id), .jtag_user_id(jtag_user_id), .cfg_loaded(cfg_loaded)
   );

   // same block on a part without the alternate ethernet pins
   dcw3_config_word #(.HAS_ALT_ETH_PINS(1'b0)) dut_no_alt_u
   (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(), .nv_rd_en(), .nv_addr(), .nv_rd_data(nv_rd_data),
      .usb_ident_pin(usb_ident_pin), .usb_id_to_usb(), .usb_id_to_port(), .usb_id_owner_usb(),
      .eth_default_pins(alt_eth_default), .eth_full_mii(), .pin_map_cfg(), .mod_dis_cfg(), .perm_grp_cfg(),
      .serial_prog_user_id(), .jtag_user_id(), .cfg_loaded()
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // storage answers the cycle after a request, otherwise shows a changing pattern
   always @(posedge clk)
   begin
      if (nv_rd_en === 1'b1)
         nv_rd_data <= nv_mem[nv_addr];
      else
         nv_rd_data <= ~nv_rd_data;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd_chk

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   // one load of word w with alternate word three a3, then every decoded field and lock
   task automatic run_case(input logic [31:0] w, input logic [31:0] a3);
      logic [15:0] la [3] = '{dcw3_pkg::ADDR_PIN_MAP, dcw3_pkg::ADDR_MOD_DIS, dcw3_pkg::ADDR_PERM_GRP};
      logic [31:0] exp;
      logic [31:0] got;
      nv_mem[0] = w;
      nv_mem[1] = a3;
      nv_mem[2] = ~a3;
      nv_mem[3] = a3 ^ 32'h00ff00ff;
      nv_mem[4] = {a3[15:0], a3[31:16]};
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      wr(dcw3_pkg::ADDR_PIN_MAP, 32'h00000001);
      rd_chk(dcw3_pkg::ADDR_STATUS, 32'h0);
      for (int i = 0; i < 30 && cfg_loaded !== 1'b1; i++)
         @(posedge clk);
      settle(2);
      chk(cfg_loaded, 32'h1);
      chk(pin_map_cfg, 32'h0);
      chk(usb_id_owner_usb, w[30]);
      chk(eth_default_pins, w[25]);
      chk(eth_full_mii, w[24]);
      chk(serial_prog_user_id, w[15:0]);
      chk(jtag_user_id, w[15:0]);
      chk(alt_eth_default, 32'h1);
      rd_chk(dcw3_pkg::ADDR_PRI_CFG3, w);
      rd_chk(dcw3_pkg::ADDR_ALT_CFG3, a3 | dcw3_pkg::CFG3_RSVD_MASK);
      rd_chk(dcw3_pkg::ADDR_ALT_CFG2, ~a3);
      rd_chk(dcw3_pkg::ADDR_ALT_CFG1, a3 ^ 32'h00ff00ff);
      rd_chk(dcw3_pkg::ADDR_ALT_CFG0, {a3[15:0], a3[31:16]});
      rd_chk(16'hff38, 32'h0);
      wr(dcw3_pkg::ADDR_PRI_CFG3, 32'h0);
      rd_chk(dcw3_pkg::ADDR_PRI_CFG3, w);
      for (int k = 0; k < 3; k++)
      begin
         wr(la[k], 32'ha5a50000 | k);
         wr(la[k], 32'h5a5a0000 | k);
         settle(2);
         exp = w[29 - k] ? (32'ha5a50000 | k) : (32'h5a5a0000 | k);
         got = (k == 0) ? pin_map_cfg : (k == 1) ? mod_dis_cfg : perm_grp_cfg;
         chk(got, exp);
         rd_chk(la[k], exp);
      end
      rd_chk(dcw3_pkg::ADDR_STATUS, {27'h0, w[30], 4'hf});
      @(posedge clk);
      usb_ident_pin <= 1'b1;
      settle(4);
      chk(usb_id_to_usb, w[30]);
      chk(usb_id_to_port, !w[30]);
      wr(dcw3_pkg::ADDR_CONTROL, 32'h1);
      settle(4);
      chk(usb_id_owner_usb, 32'h0);
      chk(usb_id_to_port, 32'h1);
      chk(usb_id_to_usb, 32'h0);
      rd_chk(dcw3_pkg::ADDR_CONTROL, 32'h1);
      wr(dcw3_pkg::ADDR_CONTROL, 32'h0);
      usb_ident_pin <= 1'b0;
      settle(4);
      chk(usb_id_owner_usb, w[30]);
      chk(usb_id_to_port, 32'h0);
   endtask : run_case

   initial
   begin
      reset_n       = 1'b0;
      reg_addr      = 16'h0;
      reg_wdata     = 32'h0;
      reg_wr        = 1'b0;
      reg_rd        = 1'b0;
      usb_ident_pin = 1'b0;
      nv_rd_data    = 32'h0;
      errors        = 0;
      compares      = 0;
      cycles        = 0;
      run_case(32'hedff1234, 32'h40005678);
      run_case(32'h96ffabcd, 32'h3b00a5a5);
      print_verdict();
   end
endmodule : dcw3_config_word_tb_top
